// ==== include/cable_regs_pkg.sv ====
// Behaviour
// - Writing one to test control bit 15 launches a measurement; bit self-clears.
// - With bit 14 set, a measurement starts automatically whenever the link drops; a drop seen while in ST_RUN starts none.
// - Bit 1 reads one once a measurement has finished, else zero.
// - Bit 0 reads one when the measurement failed, else zero.
// - Reset register bit 15 resets the whole chip like the reset pin; self-clears.
// - Reset register bit 14 restarts circuitry, keeping control values; clears when done.
// - Receive status bit 12 shows the live, unlatched link state.
// - Receive status bit 2 shows descrambler lock.
// - Receive status bit 1 shows local receiver link validity.
// - Receive status bit 0 shows remote receiver link validity.
package cable_regs_pkg;

    localparam int ADDR_W = 9;
    localparam int DATA_W = 16;

    localparam logic [8:0] CABLE_TEST_CONTROL_OFS = 9'h01E;
    localparam logic [8:0] CHIP_RESET_CONTROL_OFS = 9'h01F;
    localparam logic [8:0] LINK_RECEIVE_STATUS_OFS = 9'h180;
    localparam logic [8:0] IRQ_STATUS_OFS          = 9'h1F0;
    localparam logic [8:0] IRQ_MASK_OFS            = 9'h1F1;

    localparam int LAUNCH_BIT       = 15;
    localparam int ON_LOSS_BIT      = 14;
    localparam int COMPLETE_BIT     = 1;
    localparam int FAILED_BIT       = 0;
    localparam int HW_RESET_BIT     = 15;
    localparam int SOFT_RESTART_BIT = 14;
    localparam int LINK_BIT         = 12;
    localparam int DESCR_BIT        = 2;
    localparam int LOCAL_RX_BIT     = 1;
    localparam int REMOTE_RX_BIT    = 0;

    // Interrupt status/mask layout
    localparam int IRQ_DONE_BIT      = 0;
    localparam int IRQ_FAIL_BIT      = 1;
    localparam int IRQ_LINK_DOWN_BIT = 2;
    localparam int IRQ_W             = 3;

    localparam logic [15:0] REG_RESET_VAL = 16'h0000;
    localparam logic [2:0]  IRQ_RESET_VAL = 3'h0;

    // Chip reset pulse length (ns, then core clock cycles) and synchroniser depth
    localparam int HW_RESET_NS       = 100;
    localparam int CLK_PERIOD_NS     = 5;
    localparam int HW_RESET_CYCLES   = (HW_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYNC_STAGES       = 3;

    typedef struct packed {
        logic link_up;
        logic descr_lock;
        logic local_rx_ok;
        logic remote_rx_ok;
    } rx_status_t;

    typedef struct packed {
        logic done;
        logic failed;
    } meas_result_t;

endpackage : cable_regs_pkg

// ==== verilog/status_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module status_sync
(
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst,
    // Asynchronous in, filtered out
    input  wire logic async_in,
    output logic      sync_out
);
    logic [cable_regs_pkg::SYNC_STAGES-1:0] stage_reg;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            stage_reg <= '0;
        end
        else
        begin
            stage_reg <= {stage_reg[cable_regs_pkg::SYNC_STAGES-2:0], async_in};
        end
    end

    // Change accepted once the second and third stages agree
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            sync_out <= 1'b0;
        end
        else if (stage_reg[1] == stage_reg[2])
        begin
            sync_out <= stage_reg[2];
        end
    end
endmodule : status_sync
`default_nettype wire

// ==== verilog/cable_test_regs.sv ====
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module cable_test_regs
(
    // Clock and reset
    input  wire logic                              sys_clk,
    input  wire logic                              rst,
    // Register port
    input  wire logic [cable_regs_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [cable_regs_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                              reg_wr,
    input  wire logic                              reg_rd,
    output logic      [cable_regs_pkg::DATA_W-1:0] reg_rdata,
    // Receive status from the link logic (asynchronous)
    input  wire cable_regs_pkg::rx_status_t        rx_status_in,
    // Reflectometry engine
    output logic                                   cable_reflectometry_start,
    input  wire logic                              cable_reflectometry_busy,
    input  wire cable_regs_pkg::meas_result_t      cable_reflectometry_result,
    input  wire logic                              cable_reflectometry_result_valid,
    // Chip reset controls
    output logic                                   chip_reset_pulse,
    output logic                                   soft_restart_req,
    input  wire logic                              soft_restart_done,
    // Interrupt
    output logic                                   irq
);
    cable_regs_pkg::rx_status_t   rx_sync;
    cable_regs_pkg::meas_result_t result_reg;
    logic                         on_link_loss_reg;
    logic                         link_prev_reg;
    logic                         link_drop;
    logic                         manual_launch;
    logic                         launch;
    logic                         launch_pending_reg;
    logic                         hw_reset_reg;
    logic [7:0]                   hw_reset_cnt_reg;
    logic                         soft_restart_reg;
    logic [cable_regs_pkg::IRQ_W-1:0] irq_status_reg;
    logic [cable_regs_pkg::IRQ_W-1:0] irq_mask_reg;
    logic [cable_regs_pkg::IRQ_W-1:0] irq_events;
    logic [cable_regs_pkg::IRQ_W-1:0] irq_clear;
    logic [cable_regs_pkg::DATA_W-1:0] rdata_next;
    logic                         wr_ctrl;
    logic                         wr_reset;

    typedef enum {ST_IDLE, ST_RUN} meas_state_t;
    meas_state_t meas_state_reg;

    // Status inputs come from other clock domains
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_sync
            status_sync u_sync
            (
                .sys_clk  (sys_clk),
                .rst      (rst),
                .async_in (rx_status_in[gi]),
                .sync_out (rx_sync[gi])
            );
        end
    endgenerate

    assign wr_ctrl  = reg_wr && (reg_addr == cable_regs_pkg::CABLE_TEST_CONTROL_OFS);
    assign wr_reset = reg_wr && (reg_addr == cable_regs_pkg::CHIP_RESET_CONTROL_OFS);

    assign manual_launch = wr_ctrl && reg_wdata[cable_regs_pkg::LAUNCH_BIT];
    assign link_drop     = link_prev_reg && !rx_sync.link_up;
    assign launch        = manual_launch || (on_link_loss_reg && link_drop);

    // Auto-run enable
    always_ff @(posedge sys_clk)
    begin
        if (rst || hw_reset_reg)
        begin
            on_link_loss_reg <= 1'b0;
        end
        else if (wr_ctrl)
        begin
            on_link_loss_reg <= reg_wdata[cable_regs_pkg::ON_LOSS_BIT];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            link_prev_reg <= 1'b0;
        end
        else
        begin
            link_prev_reg <= rx_sync.link_up;
        end
    end

    // A launch seen while the engine is busy is held, one seen in ST_RUN is dropped; start is a one-cycle pulse
    always_ff @(posedge sys_clk)
    begin
        if (rst || hw_reset_reg || soft_restart_reg)
        begin
            launch_pending_reg <= 1'b0;
            meas_state_reg     <= ST_IDLE;
        end
        else
        begin
            case (meas_state_reg)
                ST_IDLE:
                begin
                    if ((launch || launch_pending_reg) && !cable_reflectometry_busy)
                    begin
                        launch_pending_reg <= 1'b0;
                        meas_state_reg     <= ST_RUN;
                    end
                    else if (launch)
                    begin
                        launch_pending_reg <= 1'b1;
                    end
                end
                ST_RUN:
                begin
                    if (cable_reflectometry_result_valid)
                    begin
                        meas_state_reg <= ST_IDLE;
                    end
                end
                default:
                begin
                    meas_state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    assign cable_reflectometry_start = (meas_state_reg == ST_IDLE)
                                       && (launch || launch_pending_reg)
                                       && !cable_reflectometry_busy
                                       && !hw_reset_reg && !soft_restart_reg;

    // Done and fail flags
    always_ff @(posedge sys_clk)
    begin
        if (rst || hw_reset_reg)
        begin
            result_reg <= '0;
        end
        else if (cable_reflectometry_start)
        begin
            result_reg <= '0;
        end
        else if (meas_state_reg == ST_RUN && cable_reflectometry_result_valid)
        begin
            result_reg.done   <= 1'b1;
            result_reg.failed <= cable_reflectometry_result.failed;
        end
    end

    // Full chip reset pulse
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            hw_reset_reg     <= 1'b0;
            hw_reset_cnt_reg <= 8'h00;
        end
        else if (hw_reset_reg)
        begin
            if (hw_reset_cnt_reg == 8'(cable_regs_pkg::HW_RESET_CYCLES - 1))
            begin
                hw_reset_reg     <= 1'b0;
                hw_reset_cnt_reg <= 8'h00;
            end
            else
            begin
                hw_reset_cnt_reg <= hw_reset_cnt_reg + 8'h01;
            end
        end
        else if (wr_reset && reg_wdata[cable_regs_pkg::HW_RESET_BIT])
        begin
            hw_reset_reg <= 1'b1;
        end
    end

    assign chip_reset_pulse = hw_reset_reg;

    // Soft restart holds until the core reports completion
    always_ff @(posedge sys_clk)
    begin
        if (rst || hw_reset_reg)
        begin
            soft_restart_reg <= 1'b0;
        end
        else if (wr_reset && reg_wdata[cable_regs_pkg::SOFT_RESTART_BIT])
        begin
            soft_restart_reg <= 1'b1;
        end
        else if (soft_restart_reg && soft_restart_done)
        begin
            soft_restart_reg <= 1'b0;
        end
    end

    assign soft_restart_req = soft_restart_reg;

    // Interrupt events; set wins over clear
    always_comb
    begin
        irq_events = '0;
        irq_events[cable_regs_pkg::IRQ_DONE_BIT] =
            (meas_state_reg == ST_RUN) && cable_reflectometry_result_valid;
        irq_events[cable_regs_pkg::IRQ_FAIL_BIT] =
            (meas_state_reg == ST_RUN) && cable_reflectometry_result_valid
            && cable_reflectometry_result.failed;
        irq_events[cable_regs_pkg::IRQ_LINK_DOWN_BIT] = link_drop;
    end

    assign irq_clear = (reg_wr && reg_addr == cable_regs_pkg::IRQ_STATUS_OFS)
                       ? reg_wdata[cable_regs_pkg::IRQ_W-1:0] : '0;

    always_ff @(posedge sys_clk)
    begin
        if (rst || hw_reset_reg)
        begin
            irq_status_reg <= cable_regs_pkg::IRQ_RESET_VAL;
        end
        else
        begin
            irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_events;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst || hw_reset_reg)
        begin
            irq_mask_reg <= cable_regs_pkg::IRQ_RESET_VAL;
        end
        else if (reg_wr && reg_addr == cable_regs_pkg::IRQ_MASK_OFS)
        begin
            irq_mask_reg <= reg_wdata[cable_regs_pkg::IRQ_W-1:0];
        end
    end

    assign irq = |(irq_status_reg & irq_mask_reg);

    // Read mux; self-clearing bits read back their live state
    always_comb
    begin
        rdata_next = cable_regs_pkg::REG_RESET_VAL;
        case (reg_addr)
            cable_regs_pkg::CABLE_TEST_CONTROL_OFS:
            begin
                rdata_next[cable_regs_pkg::LAUNCH_BIT]   = (meas_state_reg == ST_IDLE)
                                                           && launch_pending_reg;
                rdata_next[cable_regs_pkg::ON_LOSS_BIT]  = on_link_loss_reg;
                rdata_next[cable_regs_pkg::COMPLETE_BIT] = result_reg.done;
                rdata_next[cable_regs_pkg::FAILED_BIT]   = result_reg.failed;
            end
            cable_regs_pkg::CHIP_RESET_CONTROL_OFS:
            begin
                rdata_next[cable_regs_pkg::HW_RESET_BIT]     = hw_reset_reg;
                rdata_next[cable_regs_pkg::SOFT_RESTART_BIT] = soft_restart_reg;
            end
            cable_regs_pkg::LINK_RECEIVE_STATUS_OFS:
            begin
                rdata_next[cable_regs_pkg::LINK_BIT]      = rx_sync.link_up;
                rdata_next[cable_regs_pkg::DESCR_BIT]     = rx_sync.descr_lock;
                rdata_next[cable_regs_pkg::LOCAL_RX_BIT]  = rx_sync.local_rx_ok;
                rdata_next[cable_regs_pkg::REMOTE_RX_BIT] = rx_sync.remote_rx_ok;
            end
            cable_regs_pkg::IRQ_STATUS_OFS:
            begin
                rdata_next[cable_regs_pkg::IRQ_W-1:0] = irq_status_reg;
            end
            cable_regs_pkg::IRQ_MASK_OFS:
            begin
                rdata_next[cable_regs_pkg::IRQ_W-1:0] = irq_mask_reg;
            end
            default:
            begin
                rdata_next = cable_regs_pkg::REG_RESET_VAL;
            end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            reg_rdata <= cable_regs_pkg::REG_RESET_VAL;
        end
        else if (reg_rd)
        begin
            reg_rdata <= rdata_next;
        end
        else
        begin
            reg_rdata <= cable_regs_pkg::REG_RESET_VAL;
        end
    end
endmodule : cable_test_regs
`default_nettype wire

// ==== verif/cable_test_regs_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module cable_test_regs_asserts
(
    // Clock and reset
    input wire logic                              sys_clk,
    input wire logic                              rst,
    // Register port
    input wire logic [cable_regs_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [cable_regs_pkg::DATA_W-1:0] reg_wdata,
    input wire logic                              reg_wr,
    input wire logic                              reg_rd,
    input wire logic [cable_regs_pkg::DATA_W-1:0] reg_rdata,
    // Engine and resets
    input wire logic                              cable_reflectometry_start,
    input wire logic                              cable_reflectometry_busy,
    input wire logic                              cable_reflectometry_result_valid,
    input wire logic                              chip_reset_pulse,
    input wire logic                              soft_restart_req,
    input wire logic                              soft_restart_done
);
    logic [5:0] hw_cnt_reg;
    logic       run_reg;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Length of the running reset pulse
    always_ff @(posedge sys_clk)
    begin
        hw_cnt_reg <= (rst || !chip_reset_pulse) ? 6'h00 : hw_cnt_reg + 6'h01;
    end
    // Measurement in flight
    always_ff @(posedge sys_clk)
    begin
        if (rst || chip_reset_pulse)
            run_reg <= 1'h0;
        else if (cable_reflectometry_start)
            run_reg <= 1'h1;
        else if (cable_reflectometry_result_valid)
            run_reg <= 1'h0;
    end
    sequence launch_wr;
        reg_wr && reg_addr == 9'h01E && reg_wdata[15];
    endsequence
    sequence hw_wr;
        reg_wr && reg_addr == 9'h01F && reg_wdata[15] && !chip_reset_pulse;
    endsequence
    sequence soft_wr;
        reg_wr && reg_addr == 9'h01F && reg_wdata[14] && !chip_reset_pulse;
    endsequence
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data not zero outside read slot");
    start_once_a: assert property (cable_reflectometry_start |=> !cable_reflectometry_start)
        else $error("start longer than one cycle");
    start_idle_a: assert property (cable_reflectometry_start |-> !cable_reflectometry_busy)
        else $error("start while engine busy");
    launch_now_a: assert property (launch_wr ##0 (!cable_reflectometry_busy && !run_reg
        && !soft_restart_req && !chip_reset_pulse) |-> cable_reflectometry_start)
        else $error("manual launch gave no start");
    hw_cause_a: assert property (hw_wr |=> chip_reset_pulse)
        else $error("hardware reset write gave no pulse");
    hw_len_a: assert property (chip_reset_pulse |-> hw_cnt_reg < 6'h14)
        else $error("reset pulse too long");
    hw_end_a: assert property ($fell(chip_reset_pulse) |-> hw_cnt_reg == 6'h14)
        else $error("reset pulse too short");
    soft_req_a: assert property (soft_wr |=> soft_restart_req)
        else $error("restart write gave no request");
    soft_hold_a: assert property (soft_restart_req && !soft_restart_done
        && !chip_reset_pulse |=> soft_restart_req)
        else $error("restart request dropped early");
    ctrl_rsvd_a: assert property ($past(reg_rd) && $past(reg_addr) == 9'h01E
        |-> reg_rdata[13:2] == 12'h000)
        else $error("control reserved bits not zero");
    rx_rsvd_a: assert property ($past(reg_rd) && $past(reg_addr) == 9'h180
        |-> reg_rdata[15:13] == 3'h0 && reg_rdata[11:3] == 9'h000)
        else $error("status reserved bits not zero");
endmodule : cable_test_regs_asserts
bind cable_test_regs cable_test_regs_asserts cable_test_regs_asserts_inst
(
    .sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .cable_reflectometry_start, .cable_reflectometry_busy, .cable_reflectometry_result_valid,
    .chip_reset_pulse, .soft_restart_req, .soft_restart_done
);
`default_nettype wire

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic                          sys_clk = 1'h0;
    logic                          rst = 1'h1;
    logic [8:0]                    addr = 9'h000;
    logic [15:0]                   wdata = 16'h0000;
    logic                          wr = 1'h0;
    logic                          rd = 1'h0;
    logic [15:0]                   rdata;
    cable_regs_pkg::rx_status_t    rx = 4'h0;
    logic                          start;
    logic                          busy = 1'h0;
    cable_regs_pkg::meas_result_t  res = 2'h0;
    logic                          res_valid = 1'h0;
    logic                          hw_pulse;
    logic                          soft_req;
    logic                          soft_done = 1'h0;
    logic                          irq;
    logic [15:0]                   rd_val;
    logic                          st_seen;
    int                            fails = 0;
    int                            checks_done = 0;
    int                            cyc = 0;
    int                            starts = 0;
    always #2.5 sys_clk = ~sys_clk;
    cable_test_regs cable_test_regs_inst
    (
        .sys_clk(sys_clk), .rst(rst), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
        .reg_rd(rd), .reg_rdata(rdata), .rx_status_in(rx), .cable_reflectometry_start(start),
        .cable_reflectometry_busy(busy), .cable_reflectometry_result(res),
        .cable_reflectometry_result_valid(res_valid), .chip_reset_pulse(hw_pulse),
        .soft_restart_req(soft_req), .soft_restart_done(soft_done), .irq(irq)
    );
    always @(posedge sys_clk)
    begin
        starts += int'(start);
        cyc++;
        if (cyc == 4000)
        begin
            fails++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_sim
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr_reg(input logic [8:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        wr <= 1'h1;
        addr <= a;
        wdata <= d;
        #1 st_seen = start;
        @(posedge sys_clk);
        wr <= 1'h0;
        #1;
    endtask : wr_reg
    task automatic rd_chk(input logic [8:0] a, input logic [15:0] exp, input logic [15:0] m);
        @(posedge sys_clk);
        rd <= 1'h1;
        addr <= a;
        @(posedge sys_clk);
        rd <= 1'h0;
        #1 rd_val = rdata;
        chk("register read", exp, rd_val & m);
    endtask : rd_chk
    task automatic finish_meas(input logic f);
        @(posedge sys_clk);
        res_valid <= 1'h1;
        res <= {1'h1, f};
        @(posedge sys_clk);
        res_valid <= 1'h0;
    endtask : finish_meas
    task automatic wait_start(input int n);
        st_seen = 1'h0;
        repeat (n)
        begin
            #1 st_seen = st_seen | start;
            @(posedge sys_clk);
        end
    endtask : wait_start
    task automatic t_reset();
        rd_chk(9'h01E, 16'h0000, 16'hFFFF);
        rd_chk(9'h01F, 16'h0000, 16'hFFFF);
        rd_chk(9'h180, 16'h0000, 16'hFFFF);
        rd_chk(9'h0AA, 16'h0000, 16'hFFFF);
        $display("test reset done");
    endtask : t_reset
    task automatic t_rx();
        logic [15:0] exp_rx [4];
        exp_rx = '{16'h0001, 16'h0002, 16'h0004, 16'h1000};
        for (int i = 3; i >= 0; i--)
        begin
            @(posedge sys_clk);
            rx <= cable_regs_pkg::rx_status_t'(4'h1 << i);
            repeat (6) @(posedge sys_clk);
            rd_chk(9'h180, exp_rx[i], 16'hFFFF);
        end
        @(posedge sys_clk);
        rx <= 4'h0;
        repeat (6) @(posedge sys_clk);
        chk("no launch without request", 16'h0000, 16'(starts));
        $display("test rx status done");
    endtask : t_rx
    task automatic t_manual();
        wr_reg(9'h01E, 16'h8000);
        chk("start on write", 16'h0001, 16'(st_seen));
        wr_reg(9'h01E, 16'h8000);
        chk("launch ignored while running", 16'h0000, 16'(st_seen));
        finish_meas(1'h0);
        rd_chk(9'h01E, 16'h0002, 16'hFFFF);
        @(posedge sys_clk);
        busy <= 1'h1;
        wr_reg(9'h01E, 16'h8000);
        chk("start held while busy", 16'h0000, 16'(st_seen));
        rd_chk(9'h01E, 16'h8000, 16'h8000);
        @(posedge sys_clk);
        busy <= 1'h0;
        wait_start(8);
        chk("start after busy", 16'h0001, 16'(st_seen));
        rd_chk(9'h01E, 16'h0000, 16'hFFFF);
        finish_meas(1'h1);
        rd_chk(9'h01E, 16'h0003, 16'hFFFF);
        $display("test manual launch done");
    endtask : t_manual
    task automatic t_irq();
        rd_chk(9'h1F0, 16'h0007, 16'hFFFF);
        chk("irq masked", 16'h0000, 16'(irq));
        wr_reg(9'h1F1, 16'h0002);
        chk("irq raised", 16'h0001, 16'(irq));
        wr_reg(9'h1F0, 16'h0002);
        chk("irq cleared", 16'h0000, 16'(irq));
        rd_chk(9'h1F0, 16'h0005, 16'hFFFF);
        wr_reg(9'h1F0, 16'h0007);
        rd_chk(9'h1F0, 16'h0000, 16'hFFFF);
        $display("test interrupt done");
    endtask : t_irq
    task automatic t_auto();
        wr_reg(9'h01E, 16'h4000);
        @(posedge sys_clk);
        rx <= 4'h8;
        repeat (8) @(posedge sys_clk);
        rx <= 4'h0;
        wait_start(12);
        chk("auto launch", 16'h0001, 16'(st_seen));
        finish_meas(1'h0);
        rd_chk(9'h01E, 16'h4002, 16'hFFFF);
        $display("test auto launch done");
    endtask : t_auto
    task automatic t_soft();
        wr_reg(9'h01F, 16'h4000);
        chk("restart request", 16'h0001, 16'(soft_req));
        repeat (4) @(posedge sys_clk);
        rd_chk(9'h01E, 16'h4000, 16'h4000);
        @(posedge sys_clk);
        soft_done <= 1'h1;
        @(posedge sys_clk);
        soft_done <= 1'h0;
        repeat (2) @(posedge sys_clk);
        #1 chk("restart request ends", 16'h0000, 16'(soft_req));
        rd_chk(9'h01F, 16'h0000, 16'hFFFF);
        $display("test soft restart done");
    endtask : t_soft
    task automatic t_hw();
        int n;
        n = 0;
        wr_reg(9'h01F, 16'h8000);
        repeat (30)
        begin
            n += int'(hw_pulse);
            @(posedge sys_clk);
            #1;
        end
        chk("reset pulse length", 16'h0014, 16'(n));
        rd_chk(9'h01E, 16'h0000, 16'hFFFF);
        rd_chk(9'h1F1, 16'h0000, 16'hFFFF);
        rd_chk(9'h01F, 16'h0000, 16'hFFFF);
        $display("test hardware reset done");
    endtask : t_hw
    initial
    begin
        repeat (16) @(posedge sys_clk);
        rst <= 1'h0;
        t_reset();
        t_rx();
        t_manual();
        t_irq();
        t_auto();
        t_soft();
        t_hw();
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
